// File: src/tmr_timer16.sv
// Mode and capture/compare control of a 16-bit timer, AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
module tmr_timer16
    import tmr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Timer pins
    input  wire logic        event_input_zero_in,
    input  wire logic        event_input_one_in,
    output logic             timer_output_out,
    output logic      [1:0]  match_capture_irq_out
);
    //==========================================================
    // Helpers
    function automatic logic edge_hit(input logic p, input logic c,
                                      input logic [1:0] sel);
        case (sel)
            EDGE_FALL: edge_hit = p & ~c;
            EDGE_RISE: edge_hit = ~p & c;
            EDGE_BOTH: edge_hit = p ^ c;
            default:   edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    function automatic logic [31:0] byte_addr(input logic [15:0] idx);
        byte_addr = {14'h0000, idx, 2'b00};
    endfunction : byte_addr

    //==========================================================
    // State
    tmr_mode_t     mode_r;
    tmr_prescale_t pscl_r;
    logic [2:0]    ccctl_r;
    logic [15:0]   main_count_r;
    logic [15:0]   capcmp_reg_zero_r;
    logic [15:0]   capcmp_reg_one_r;
    logic [7:0]    div_r;
    logic          ev0_prev_r;
    logic          ev1_prev_r;
    logic          ovf_hold_r;
    logic [1:0]    cap_pend_r;
    logic [1:0]    irq_due_r;
    logic          wr_pend_r;
    logic [15:0]   wr_idx_r;
    logic [31:0]   hrdata_r;

    logic running, tick, ev0_edge, ev1_edge, ev0_rev;
    logic match0, match1, cap0_trig, cap1_trig;
    logic addr_ok, wr_mode, wr_cc, ovf_set;
    logic [15:0] ahb_idx;

    //==========================================================
    // Count clock and event edges
    assign running = (mode_r.mode_sel != MODE_STOP);
    // Events only seen while running; prev levels freeze when stopped
    assign ev0_edge = running &
        edge_hit(ev0_prev_r, event_input_zero_in, pscl_r.edge_zero);
    assign ev1_edge = running &
        edge_hit(ev1_prev_r, event_input_one_in, pscl_r.edge_one);
    // Opposite phase; both-edge setting maps to no capture
    assign ev0_rev = running & (pscl_r.edge_zero != EDGE_BOTH) &
        edge_hit(ev0_prev_r, event_input_zero_in,
                 pscl_r.edge_zero ^ 2'b01);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ev0_prev_r <= 1'b0;
            ev1_prev_r <= 1'b0;
        end else if (running) begin
            ev0_prev_r <= event_input_zero_in;
            ev1_prev_r <= event_input_one_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_r <= 8'h00;
        end else if (!running) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // Divider restarts on every start, so each run opens with a full period
    always_comb begin
        case (pscl_r.clk_sel)
            2'h0:    tick = running;
            2'h1:    tick = running &
                         (div_r[1:0] == 2'(DIV_QUARTER - 1));
            2'h2:    tick = running &
                         (div_r == 8'(DIV_SLOW - 1));
            default: tick = ev0_edge;
        endcase
    end

    //==========================================================
    // Counter
    // A register in capture mode never matches, so it cannot toggle
    assign match0 = ~ccctl_r[CC_ZERO_CAP] &
        (main_count_r == capcmp_reg_zero_r);
    assign match1 = ~ccctl_r[CC_ONE_CAP] &
        (main_count_r == capcmp_reg_one_r);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            main_count_r <= 16'h0000;
        end else if (!running) begin
            main_count_r <= 16'h0000;
        end else if (mode_r.mode_sel == MODE_CLR_E && ev0_edge) begin
            main_count_r <= 16'h0000;
        end else if (tick) begin
            if (mode_r.mode_sel == MODE_CLR_M &&
                main_count_r == capcmp_reg_zero_r) begin
                main_count_r <= 16'h0000;
            end else begin
                main_count_r <= main_count_r + 16'h0001;
            end
        end
    end

    // Wrap seen on a tick at the top value in any running mode
    assign ovf_set = tick & (main_count_r == CNT_MAX);

    // Holds the re-set window until the count moves past 0000
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovf_hold_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_hold_r <= 1'b1;
        end else if (tick || !running) begin
            ovf_hold_r <= 1'b0;
        end
    end

    //==========================================================
    // Capture and interrupts
    assign cap0_trig = ccctl_r[CC_ZERO_CAP] &
        (ccctl_r[CC_ZERO_TRG] ? ev0_rev : ev1_edge);
    assign cap1_trig = ccctl_r[CC_ONE_CAP] & ev0_edge;

    // Trigger waits for the count tick, which stands for the fall
    // Triggers between slow ticks are merged, not lost
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cap_pend_r <= 2'b00;
            irq_due_r  <= 2'b00;
        end else if (!running) begin
            cap_pend_r <= 2'b00;
            irq_due_r  <= 2'b00;
        end else begin
            if (tick) begin
                cap_pend_r <= {cap1_trig, cap0_trig};
                irq_due_r  <= cap_pend_r;
            end else begin
                cap_pend_r <= cap_pend_r | {cap1_trig, cap0_trig};
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            match_capture_irq_out <= 2'b00;
        end else if (!running) begin
            match_capture_irq_out <= 2'b00;
        end else if (tick) begin
            match_capture_irq_out <= irq_due_r |
                                     {match1, match0};
        end else begin
            match_capture_irq_out <= 2'b00;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            timer_output_out <= 1'b0;
        end else if (running) begin
            if ((tick && (match0 || match1)) ||
                (mode_r.toggle_src_sel && ev0_edge)) begin
                timer_output_out <= ~timer_output_out;
            end
        end
    end

    //==========================================================
    // AHB-Lite slave: zero wait, always OKAY
    assign ahb_idx = haddr_in[17:2];
    // Only aligned word addresses of the low map decode
    assign addr_ok = (haddr_in == byte_addr(ahb_idx));
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_r;
    assign wr_mode = wr_pend_r & (wr_idx_r == IDX_MODE);
    assign wr_cc   = wr_pend_r & (wr_idx_r == IDX_CCCTL);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 16'h0000;
        end else if (hready_in) begin
            wr_pend_r <= hsel_in & htrans_in[1] & hwrite_in & addr_ok;
            wr_idx_r  <= ahb_idx;
        end
    end

    // Read data is latched in the address phase
    // A write is not seen by a read in the very next address phase
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hrdata_r <= 32'h00000000;
        end else if (hready_in && hsel_in && htrans_in[1] &&
                     !hwrite_in) begin
            hrdata_r <= 32'h00000000;
            if (addr_ok) begin
                case (ahb_idx)
                    IDX_MODE:     hrdata_r <= {28'h0000000, mode_r};
                    IDX_PRESCALE: hrdata_r <= {24'h000000, pscl_r};
                    IDX_CCCTL:    hrdata_r <= {29'h00000000, ccctl_r};
                    IDX_CAP0:     hrdata_r <= {16'h0000,
                                               capcmp_reg_zero_r};
                    IDX_CAP1:     hrdata_r <= {16'h0000,
                                               capcmp_reg_one_r};
                    IDX_COUNT:    hrdata_r <= {16'h0000, main_count_r};
                    default:      hrdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    //==========================================================
    // Control registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_r <= tmr_mode_t'(RST_MODE[3:0]);
        end else begin
            if (wr_mode) begin
                mode_r <= tmr_mode_t'(hwdata_in[3:0]);
            end
            // Set wins over a software clear
            if (ovf_set || ovf_hold_r) begin
                mode_r.overflow_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ccctl_r <= RST_CCCTL[2:0];
        end else if (wr_cc) begin
            ccctl_r <= hwdata_in[2:0];
        end
    end

    // Reserved prescale bits 3:2 always read as zero
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pscl_r <= tmr_prescale_t'(RST_PRESCALE);
        end else if (wr_pend_r && wr_idx_r == IDX_PRESCALE) begin
            pscl_r <= tmr_prescale_t'({hwdata_in[7:4], 2'b00,
                                       hwdata_in[1:0]});
        end
    end

    // Compare mode: software load; capture mode: latched count
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            capcmp_reg_zero_r <= RST_CAPCMP;
        end else if (tick && cap_pend_r[0]) begin
            capcmp_reg_zero_r <= main_count_r;
        end else if (wr_pend_r && wr_idx_r == IDX_CAP0) begin
            capcmp_reg_zero_r <= hwdata_in[15:0];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            capcmp_reg_one_r <= RST_CAPCMP;
        end else if (tick && cap_pend_r[1]) begin
            capcmp_reg_one_r <= main_count_r;
        end else if (wr_pend_r && wr_idx_r == IDX_CAP1) begin
            capcmp_reg_one_r <= hwdata_in[15:0];
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize_in, hwdata_in[31:16]};
endmodule : tmr_timer16
`default_nettype wire

// File: src/tmr_pkg.sv
// Package with register map, field layout and timing for the timer block
//==========================================================
// Contract
// - Reset clears mode control register to zero; counter stopped.
// - Counter runs while upper mode bits are nonzero; stops at zero.
// - Mode bits 3:2 pick stop, free-run, clear on edge, clear on match.
// - Output toggles on matches, plus event zero edge if bit 1 set.
// - No interrupts when stopped; compare match or capture edges raise.
// - Mode bit 0 is overflow flag, set once overflow seen.
// - Event inputs ignored entirely while counter stopped; levels freeze, so a change while stopped is seen as an edge on restart.
// - Overflow flag set on wrap FFFF to 0000 in running modes.
// - Clearing flag before count reaches 0001 is overridden.
// - Capture on count clock tick, interrupt on following tick.
// - Both control registers load their low data bits on any write; size ignored.
// - Reset clears capture/compare control; both registers compare.
// - Control bit 2 makes register one capture instead of compare.
// - Control bit 0 makes register zero capture instead of compare.
// - Control bit 1 picks register zero trigger: event one or zero.
// - Opposite-phase trigger with both edges valid takes no capture.
// - Returning to stop resets the counter to zero.
// - Compare registers checked on each count tick; equality raises irq.
//==========================================================
package tmr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE     = 16'hff60;
    localparam logic [15:0] IDX_PRESCALE = 16'hff61;
    localparam logic [15:0] IDX_CCCTL    = 16'hff62;
    localparam logic [15:0] IDX_CAP0     = 16'hff64;
    localparam logic [15:0] IDX_CAP1     = 16'hff66;
    localparam logic [15:0] IDX_COUNT    = 16'hff68;
    localparam logic [7:0]  RST_MODE     = 8'h00;
    localparam logic [7:0]  RST_CCCTL    = 8'h00;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [15:0] RST_CAPCMP   = 16'h0000;
    // Mode field values (bits 3:2)
    localparam logic [1:0] MODE_STOP  = 2'h0;
    localparam logic [1:0] MODE_FREE  = 2'h1;
    localparam logic [1:0] MODE_CLR_E = 2'h2;
    localparam logic [1:0] MODE_CLR_M = 2'h3;
    // Field positions
    localparam int CC_ONE_CAP  = 2;
    localparam int CC_ZERO_TRG = 1;
    localparam int CC_ZERO_CAP = 0;
    // Edge selection codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Count clock divider ratios
    localparam int DIV_QUARTER = 4;
    localparam int DIV_SLOW    = 256;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    typedef struct packed {
        logic [1:0] mode_sel;
        logic       toggle_src_sel;
        logic       overflow_flag;
    } tmr_mode_t;

    typedef struct packed {
        logic [1:0] edge_one;
        logic [1:0] edge_zero;
        logic [1:0] unused;
        logic [1:0] clk_sel;
    } tmr_prescale_t;
endpackage : tmr_pkg

// File: verification/tmr_timer16_asserts.sv
// Port checker for the timer control block
`timescale 1ns/1ns
`default_nettype none
module tmr_timer16_asserts
    import tmr_pkg::*;
(
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    // Bus
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [2:0]  hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // Timer pins
    input wire logic        event_input_zero_in,
    input wire logic        event_input_one_in,
    input wire logic        timer_output_out,
    input wire logic [1:0]  match_capture_irq_out
);
    //==========================================================
    // Shadow of bus traffic
    localparam logic [31:0] A_MODE = {14'h0, IDX_MODE, 2'h0};
    localparam logic [31:0] A_CC   = {14'h0, IDX_CCCTL, 2'h0};
    localparam logic [31:0] A_CNT  = {14'h0, IDX_COUNT, 2'h0};
    logic        ph_r;
    logic        wr_r;
    logic        rd_q;
    logic        known;
    logic [31:0] adr_r;
    logic [2:0]  mode_r;
    logic [2:0]  cc_r;
    logic [1:0]  stop_r;
    assign rd_q  = ph_r && !wr_r;
    assign known = adr_r[31:18] == 14'h0 && adr_r[1:0] == 2'h0 &&
        adr_r[17:2] inside {IDX_MODE, IDX_PRESCALE, IDX_CCCTL, IDX_CAP0,
                            IDX_CAP1, IDX_COUNT};
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ph_r   <= 1'b0;
            wr_r   <= 1'b0;
            adr_r  <= 32'h0;
            mode_r <= 3'h0;
            cc_r   <= 3'h0;
            stop_r <= 2'h0;
        end else begin
            if (hready_in) begin
                ph_r  <= hsel_in && htrans_in[1];
                wr_r  <= hwrite_in;
                adr_r <= haddr_in;
            end
            if (ph_r && wr_r && adr_r == A_MODE)
                mode_r <= hwdata_in[3:1];
            if (ph_r && wr_r && adr_r == A_CC)
                cc_r <= hwdata_in[2:0];
            // Stop needs a few cycles to settle the registered outputs
            if (mode_r[2:1] != MODE_STOP)
                stop_r <= 2'h0;
            else if (stop_r != 2'h3)
                stop_r <= stop_r + 2'h1;
        end
    end
    //==========================================================
    // Properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_resp_okay: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    a_rst_quiet: assert property ($rose(reset_n_in) |->
        !timer_output_out && match_capture_irq_out == 2'h0)
        else $error("outputs active after reset");
    a_irq_pulse: assert property (|match_capture_irq_out |=>
        (match_capture_irq_out & $past(match_capture_irq_out)) == 2'h0)
        else $error("interrupt longer than one cycle");
    a_stop_quiet: assert property (stop_r == 2'h3 |->
        match_capture_irq_out == 2'h0 && $stable(timer_output_out))
        else $error("activity while stopped");
    a_unmapped_zero: assert property (rd_q && !known |->
        hrdata_out == 32'h0) else $error("unmapped read not zero");
    a_mode_readback: assert property (rd_q && adr_r == A_MODE |->
        hrdata_out[31:1] == {28'h0, mode_r}) else $error("mode readback");
    a_cc_readback: assert property (rd_q && adr_r == A_CC |->
        hrdata_out == {29'h0, cc_r}) else $error("control readback");
    a_count_stop: assert property (
        rd_q && adr_r == A_CNT && stop_r[1] |-> hrdata_out == 32'h0)
        else $error("count not zero when stopped");
endmodule : tmr_timer16_asserts
bind tmr_timer16 tmr_timer16_asserts i_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .event_input_zero_in(event_input_zero_in),
    .event_input_one_in(event_input_one_in),
    .timer_output_out(timer_output_out),
    .match_capture_irq_out(match_capture_irq_out));
`default_nettype wire

// File: verification/tmr_timer16_bench.sv
// Self-checking bench of the timer control block
`timescale 1ns/1ns
`default_nettype none
module tmr_timer16_bench
    import tmr_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        ev0 = 1'b0, ev1 = 1'b0, ready, resp, tout, t0;
    logic [1:0]  htrans = 2'h0, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata, v;
    int          errors = 0, checks_done = 0, n, irq_cnt = 0, base;
    always #10 clk = ~clk;
    always @(posedge clk) if (|irq) irq_cnt <= irq_cnt + 1;
    tmr_timer16 i_dut (
        .clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(ready), .hrdata_out(rdata),
        .hreadyout_out(ready), .hresp_out(resp),
        .event_input_zero_in(ev0), .event_input_one_in(ev1),
        .timer_output_out(tout), .match_capture_irq_out(irq));
    //==========================================================
    // Tasks
    task automatic end_sim();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h, expected %h",
                     $time, seen, exp);
        end
    endtask : check
    // Bounded wait on irq bit 0 or 1, or on ready when sel is 2
    task automatic waitc(input int sel, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel == 2 ? ready : irq[sel]) !== 1'b1 && n < lim);
        if ((sel == 2 ? ready : irq[sel]) !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask : waitc
    task automatic bus(input logic [15:0] idx, input logic is_wr,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= is_wr;
        waitc(2, 20);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitc(2, 20);
        v = rdata;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        bus(idx, 1'b1, wd);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        check(v, exp);
    endtask : rd
    //==========================================================
    // Tests
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(IDX_MODE, {24'h0, RST_MODE});
        rd(IDX_CCCTL, {24'h0, RST_CCCTL});
        rd(16'hff6a, 32'h0);
        // Nonzero compare value keeps clear-on-match from firing each tick
        wr(IDX_CAP0, 32'h1000);
        for (int i = 1; i < 8; i++) begin
            wr(IDX_CCCTL, 32'(i));
            rd(IDX_CCCTL, 32'(i));
            wr(IDX_MODE, 32'(i * 2));
            rd(IDX_MODE, 32'(i * 2));
            wr(IDX_MODE, 32'h0);
        end
        $display("test registers done");
        wr(IDX_CCCTL, 32'h5);
        wr(IDX_PRESCALE, 32'hf0);
        base = irq_cnt;
        t0 = tout;
        repeat (4) begin
            ev0 <= ~ev0;
            ev1 <= ~ev1;
            repeat (3) @(posedge clk);
        end
        check(32'(irq_cnt - base), 32'h0);
        check({31'h0, tout}, {31'h0, t0});
        rd(IDX_COUNT, 32'h0);
        $display("test stopped done");
        wr(IDX_CCCTL, 32'h1);
        wr(IDX_PRESCALE, 32'h40);
        wr(IDX_CAP1, 32'h100);
        wr(IDX_MODE, 32'h4);
        repeat (8) @(posedge clk);
        ev1 <= 1'b1;
        waitc(0, 10);
        check(32'(n >= 2 && n <= 4), 32'h1);
        bus(IDX_CAP0, 1'b0, 32'h0);
        check(32'(v != 0 && v < 32'h20), 32'h1);
        wr(IDX_MODE, 32'h0);
        ev1 <= 1'b0;
        $display("test capture done");
        wr(IDX_CCCTL, 32'h0);
        wr(IDX_CAP1, 32'h20);
        wr(IDX_CAP0, 32'h40);
        t0 = tout;
        wr(IDX_MODE, 32'h4);
        waitc(1, 100);
        @(posedge clk);
        check({31'h0, tout}, {31'h0, ~t0});
        waitc(0, 100);
        check(32'(n), 32'd31);
        repeat (2) @(posedge clk);
        check({31'h0, tout}, {31'h0, t0});
        bus(IDX_COUNT, 1'b0, 32'h0);
        check(32'(v > 32'h40), 32'h1);
        wr(IDX_MODE, 32'h0);
        @(posedge clk);
        rd(IDX_COUNT, 32'h0);
        $display("test compare done");
        wr(IDX_CAP0, 32'h10);
        wr(IDX_PRESCALE, 32'h1);
        wr(IDX_MODE, 32'hc);
        waitc(0, 100);
        waitc(0, 100);
        check(32'(n), 32'(17 * DIV_QUARTER));
        wr(IDX_MODE, 32'h0);
        $display("test clear on match done");
        wr(IDX_CCCTL, 32'h4);
        wr(IDX_PRESCALE, 32'h10);
        t0 = tout;
        wr(IDX_MODE, 32'ha);
        repeat (8) @(posedge clk);
        ev0 <= 1'b1;
        waitc(1, 10);
        check(32'(n), 32'd4);
        check({31'h0, tout}, {31'h0, ~t0});
        rd(IDX_CAP1, 32'h0);
        wr(IDX_MODE, 32'h0);
        ev0 <= 1'b0;
        $display("test clear on edge done");
        wr(IDX_CCCTL, 32'h3);
        wr(IDX_CAP1, 32'hffff);
        wr(IDX_PRESCALE, 32'h30);
        wr(IDX_MODE, 32'h4);
        base = irq_cnt;
        repeat (4) begin
            ev0 <= ~ev0;
            repeat (3) @(posedge clk);
        end
        check(32'(irq_cnt - base), 32'h0);
        rd(IDX_CAP0, 32'h10);
        wr(IDX_MODE, 32'h0);
        wr(IDX_PRESCALE, 32'h10);
        wr(IDX_MODE, 32'h4);
        ev0 <= 1'b1;
        repeat (3) @(posedge clk);
        check(32'(irq_cnt - base), 32'h0);
        ev0 <= 1'b0;
        waitc(0, 10);
        check(32'(n), 32'd4);
        wr(IDX_MODE, 32'h0);
        wr(IDX_CCCTL, 32'h0);
        $display("test reverse trigger done");
        wr(IDX_CAP0, 32'hffff);
        wr(IDX_MODE, 32'h4);
        waitc(0, 70000);
        repeat (2) @(posedge clk);
        rd(IDX_MODE, 32'h5);
        wr(IDX_MODE, 32'h4);
        rd(IDX_MODE, 32'h4);
        wr(IDX_MODE, 32'h0);
        $display("test overflow done");
        end_sim();
    end
endmodule : tmr_timer16_bench
`default_nettype wire
